// *** dv/itsp_bus_partner.sv ***
// partner: far-side talker, listener and poll controller with resolved bus lines
`timescale 1ns/10ps
`default_nettype none
module itsp_bus_partner (
	input  wire logic                    pclk,  // clock
	input  wire logic                    lsn,   // act as listener
	input  wire itsp_pkg::itsp_bus_out_s drv,   // design drive
	output var  itsp_pkg::itsp_bus_in_s  lines, // resolved levels
	output var  logic [8:0]              rx_w,  // eoi and byte last taken
	output var  logic [7:0]              rx_n   // bytes taken
);
	import itsp_pkg::*;
	logic [7:0] dio_p;
	logic       dav_p, eoi_p, atn_p, nrfd_p, ndac_p; // pulls, high asserts
	initial begin
		dio_p  = 8'h00;
		dav_p  = 1'b0;
		eoi_p  = 1'b0;
		atn_p  = 1'b0;
		nrfd_p = 1'b0;
		ndac_p = 1'b0;
		rx_w   = 9'h000;
		rx_n   = 8'h00;
	end
	////////////////////////////////////////
	// open-drain lines with pull-ups, low when anyone pulls
	assign lines = {~(drv.dio_oe | dio_p), ~(drv.dav_oe | dav_p), ~(drv.nrfd_oe | nrfd_p),
		~(drv.ndac_oe | ndac_p), ~(drv.eoi_oe | eoi_p), ~(drv.atn_oe | atn_p)};
	// acceptor: hold ndac, take byte on dav, rearm on dav release
	always @(posedge pclk) begin
		if (!lsn) begin
			ndac_p <= 1'b0;
			nrfd_p <= 1'b0;
		end else if (!lines.dav && ndac_p) begin
			rx_w   <= {!lines.eoi, ~lines.dio};
			rx_n   <= rx_n + 8'h01;
			ndac_p <= 1'b0;
			nrfd_p <= 1'b1;
		end else if (lines.dav) begin
			ndac_p <= 1'b1;
			nrfd_p <= 1'b0;
		end
	end
	// talker: one byte, optional eoi and atn, released after the handshake
	task automatic talk(input logic [7:0] b, input logic e, input logic a);
		int n;
		@(posedge pclk);
		dio_p <= b;
		eoi_p <= e;
		atn_p <= a;
		repeat (2) @(posedge pclk);
		for (n = 0; n < 200 && lines.nrfd !== 1'b1; n++)
			@(posedge pclk);
		dav_p <= 1'b1;
		@(posedge pclk);
		for (n = 0; n < 200 && lines.ndac !== 1'b1; n++)
			@(posedge pclk);
		dav_p <= 1'b0;
		dio_p <= 8'h00;
		eoi_p <= 1'b0;
		atn_p <= 1'b0;
	endtask : talk
	// identify: eoi together with atn while on is high
	task automatic poll(input logic on);
		@(posedge pclk);
		atn_p <= on;
		eoi_p <= on;
	endtask : poll
endmodule : itsp_bus_partner
`default_nettype wire

// *** dv/itsp_top_assertions.sv ***
// checker: apb answer, standby, poll and handshake relations at the ports
`timescale 1ns/10ps
`default_nettype none
module itsp_top_assertions (
	input wire logic                    pclk,    // clock
	input wire logic                    presetn, // reset, active low
	input wire logic                    psel,    // apb select
	input wire logic                    penable, // apb access
	input wire logic                    pwrite,  // apb direction
	input wire logic [7:0]              paddr,   // apb address
	input wire logic [31:0]             pwdata,  // apb write data
	input wire logic [31:0]             prdata,  // apb read data
	input wire logic                    pready,  // apb ready
	input wire logic                    pslverr, // apb error
	input wire itsp_pkg::itsp_bus_in_s  bus_i,   // line levels
	input wire itsp_pkg::itsp_bus_out_s bus_o    // line drive
);
	import itsp_pkg::*;
	logic sby_wr;   // standby written without take or controller set
	logic unmapped; // address outside the map
	assign sby_wr   = pready && psel && penable && pwrite && paddr == ITSP_ADDR_CTRL
		&& pwdata[ITSP_CTRL_STANDBY] && !pwdata[ITSP_CTRL_TAKE] && !pwdata[ITSP_CTRL_CIC_SET];
	assign unmapped = paddr[1:0] != 2'h0 || paddr > ITSP_ADDR_RXD;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	////////////////////////////////////////
	// apb answer
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_ready_after_setup: assert property (psel && !penable && !pready |=> pready)
		else $error("no ready after setup");
	a_err_unmapped: assert property (pready |-> pslverr == unmapped)
		else $error("error flag wrong for address");
	a_err_reads_zero: assert property (pready && pslverr |-> prdata == 32'h0)
		else $error("refused read gave data");
	// controller and poll lines
	a_atn_standby: assert property (sby_wr |-> ##[1:2] !bus_o.atn_oe)
		else $error("atn kept after standby");
	a_poll_onehot: assert property ((!bus_i.atn && !bus_i.eoi && !bus_o.dav_oe) [*2] |-> $onehot0(bus_o.dio_oe))
		else $error("poll drives several lines");
	// source and acceptor handshake
	a_data_stable: assert property (bus_o.dav_oe && $past(bus_o.dav_oe) |-> $stable({bus_o.dio_oe, bus_o.eoi_oe}))
		else $error("data or eoi moved under dav");
	a_dav_release: assert property ($fell(bus_o.dav_oe) |-> $past(bus_i.ndac))
		else $error("dav released before ndac");
	a_hold_kept: assert property ((bus_o.nrfd_oe && bus_o.ndac_oe) [*3] ##0
		(!pready && !$past(pready) && !$past(pready, 2) && $stable(bus_i.atn)) |=> bus_o.nrfd_oe)
		else $error("nrfd holdoff dropped");
	// main scenarios
	c_refused: cover property (pready && pslverr);
	c_source: cover property ($rose(bus_o.dav_oe));
	c_identify: cover property (!bus_i.atn && !bus_i.eoi);
endmodule : itsp_top_assertions
bind itsp_top itsp_top_assertions chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.bus_i(bus_i), .bus_o(bus_o));
`default_nettype wire

// *** dv/tb.sv ***
// testbench: registers, end signalling, read termination, standby and poll
`timescale 1ns/10ps
`default_nettype none
module tb;
	import itsp_pkg::*;
	logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, lsn;
	logic [7:0]    paddr, rx_n;
	logic [8:0]    rx_w;
	logic [31:0]   pwdata, prdata, rd_v;
	logic          rd_e;
	itsp_bus_in_s  bus_i;
	itsp_bus_out_s bus_o;
	int            errors, cmp_count;
	itsp_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.bus_i(bus_i), .bus_o(bus_o));
	itsp_bus_partner partner_u (.pclk(pclk), .lsn(lsn), .drv(bus_o), .lines(bus_i), .rx_w(rx_w), .rx_n(rx_n));
	always #20 pclk = ~pclk;
	////////////////////////////////////////
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	// apb transfer: setup, then access held until ready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd_v = prdata;
		rd_e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd_v & m, e);
	endtask : rd
	task automatic ctl(input logic [31:0] v);
		apb(1'b1, ITSP_ADDR_CTRL, v);
		repeat (3) @(posedge pclk);
	endtask : ctl
	// one byte sourced by the block, caught by the partner
	task automatic send(input logic [15:0] eos, input logic [8:0] t, input logic e);
		logic [7:0] n0;
		apb(1'b1, ITSP_ADDR_EOS, {16'h0, eos});
		n0 = rx_n;
		apb(1'b1, ITSP_ADDR_TXD, {23'h0, t});
		for (int k = 0; k < 100 && rx_n == n0; k++)
			@(posedge pclk);
		repeat (4) @(posedge pclk);
		chk({23'h0, rx_w}, {23'h0, e, t[7:0]});
		chk({24'h0, rx_n}, {24'h0, n0 + 8'h01});
	endtask : send
	// one byte from the partner, taken by the listening block
	task automatic recv(input logic [15:0] eos, input logic [31:0] e);
		apb(1'b1, ITSP_ADDR_EOS, {16'h0, eos});
		ctl(32'h1 << ITSP_CTRL_LISTEN);
		partner_u.talk(8'h8A, 1'b0, 1'b0);
		repeat (4) @(posedge pclk);
		rd(ITSP_ADDR_RXD, 32'h1FF, e);
	endtask : recv
	task automatic print_verdict();
		if (errors == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : print_verdict
	////////////////////////////////////////
	initial begin
		pclk      = 1'b0;
		presetn   = 1'b0;
		psel      = 1'b0;
		penable   = 1'b0;
		pwrite    = 1'b0;
		paddr     = 8'h00;
		pwdata    = 32'h0;
		lsn       = 1'b1;
		errors    = 0;
		cmp_count = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		// reset values, refused address, previous values
		rd(ITSP_ADDR_AUTO_END, '1, 32'h1);
		rd(ITSP_ADDR_EOS, '1, 32'h0);
		rd(8'h24, '1, 32'h0);
		chk(32'(rd_e), 32'h1);
		apb(1'b1, ITSP_ADDR_EOS, 32'hFFFF);
		rd(ITSP_ADDR_EOS, '1, 32'h1CFF);
		apb(1'b1, ITSP_ADDR_IST, 32'h5);
		rd(ITSP_ADDR_ERR, '1, 32'h0);
		rd(ITSP_ADDR_IST, '1, 32'h1);
		apb(1'b1, ITSP_ADDR_IST, 32'h0);
		rd(ITSP_ADDR_ERR, '1, 32'h1);
		rd(ITSP_ADDR_IST, '1, 32'h0);
		apb(1'b1, ITSP_ADDR_AUTO_END, 32'h0);
		rd(ITSP_ADDR_ERR, '1, 32'h1);
		apb(1'b1, ITSP_ADDR_AUTO_END, 32'h0);
		rd(ITSP_ADDR_ERR, '1, 32'h0);
		// sourced bytes with and without end signalling
		send(16'h0000, 9'h141, 1'b0);
		ctl(32'h1 << ITSP_CTRL_DEFAULTS);
		send(16'h0000, 9'h141, 1'b1);
		apb(1'b1, ITSP_ADDR_AUTO_END, 32'h0);
		send(16'h080A, 9'h08A, 1'b1);
		send(16'h180A, 9'h08A, 1'b0);
		send(16'h180A, 9'h00A, 1'b1);
		// received bytes against the string options
		lsn <= 1'b0;
		recv(16'h040A, 32'h18A);
		recv(16'h140A, 32'h08A);
		recv(16'h000A, 32'h08A);
		// standby refused, then granted with shadow handshake
		ctl(32'h1 << ITSP_CTRL_UNLISTEN);
		ctl(32'h1 << ITSP_CTRL_STANDBY);
		rd(ITSP_ADDR_STATUS, 32'h40, 32'h40);
		ctl(32'h1 << ITSP_CTRL_CIC_SET);
		chk(32'(bus_i.atn), 32'h0);
		apb(1'b1, ITSP_ADDR_EOS, 32'h0);
		ctl((32'h1 << ITSP_CTRL_STANDBY) | (32'h1 << ITSP_CTRL_SHADOW));
		chk(32'(bus_i.atn), 32'h1);
		rd(ITSP_ADDR_STATUS, 32'h40, 32'h0);
		partner_u.talk(8'h55, 1'b1, 1'b0);
		rd(ITSP_ADDR_STATUS, 32'h80, 32'h0);
		chk(32'(bus_i.nrfd), 32'h0);
		ctl(32'h1 << ITSP_CTRL_TAKE);
		chk(32'(bus_i.nrfd), 32'h1);
		chk(32'(bus_i.atn), 32'h0);
		ctl(32'h1 << ITSP_CTRL_STANDBY);
		chk(32'({bus_o.nrfd_oe, bus_o.ndac_oe}), 32'h0);
		// parallel poll, local then remote configuration
		ctl(32'h1 << ITSP_CTRL_CIC_CLR);
		apb(1'b1, ITSP_ADDR_PPE, 32'h1A);
		apb(1'b1, ITSP_ADDR_IST, 32'h1);
		partner_u.poll(1'b1);
		repeat (3) @(posedge pclk);
		chk(32'(bus_o.dio_oe), 32'h04);
		apb(1'b1, ITSP_ADDR_IST, 32'h0);
		repeat (3) @(posedge pclk);
		chk(32'(bus_o.dio_oe), 32'h00);
		partner_u.poll(1'b0);
		partner_u.talk(8'h65, 1'b0, 1'b1);
		partner_u.poll(1'b1);
		repeat (3) @(posedge pclk);
		chk(32'(bus_o.dio_oe), 32'h20);
		partner_u.poll(1'b0);
		print_verdict();
	end
	// watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge pclk);
		errors++;
		print_verdict();
	end
endmodule : tb
`default_nettype wire

// *** hdl/itsp_top.sv ***
// design: end-of-string termination, controller standby with shadow handshake, parallel poll response
// Summary of operation
// - auto end enabled adds END to final written byte; disabled adds END only on a write-end string match
// - restoring defaults enables automatic end on the final byte
// - END is carried by asserting EOI during that byte
// - END with matching string byte depends only on end-of-string setup
// - string byte is never inserted; only supplied data goes out
// - device-level string options govern all its reads and writes
// - board-level end method governs all board writes, any listener
// - full compare ends reads only on all eight bits matching
// - read terminate cleared means a matching byte does not end reads
// - standby request as controller releases ATN and enters standby
// - shadow option makes the block an acceptor that keeps no bytes
// - shadowing, END seen makes the block hold NRFD asserted
// - shadow clear means no handshake and no holdoff in standby
// - after a holdoff control can be taken again synchronously
// - standby request refused with not-controller error unless in charge
// - during identify the assigned line follows status bit and sense
// - poll line and sense come from local or remote poll enable
// - nonzero write sets the individual status bit, zero clears it
// - status bit update returns the previous bit in the detail word
// - auto end update returns one if previously enabled, else zero
// - string word holds match byte low and three flags high
// - without full compare the low seven bits decide a match
// - write-end flag sends END with any written byte that matches
`timescale 1ns/10ps
`default_nettype none

module itsp_top (
	input  wire logic                   pclk,     // apb clock, 25 MHz
	input  wire logic                   presetn,  // async reset, active low
	input  wire logic                   psel,     // apb select
	input  wire logic                   penable,  // apb access phase
	input  wire logic                   pwrite,   // apb direction, high writes
	input  wire logic [7:0]             paddr,    // apb byte address
	input  wire logic [31:0]            pwdata,   // apb write data
	output var  logic [31:0]            prdata,   // apb read data
	output var  logic                   pready,   // apb ready
	output var  logic                   pslverr,  // apb error, unmapped address
	input  wire itsp_pkg::itsp_bus_in_s bus_i,    // bus line levels
	output var  itsp_pkg::itsp_bus_out_s bus_o    // bus line drive
);
	import itsp_pkg::*;

	typedef struct packed {
		logic          pready;
		logic          pslverr;
		logic [31:0]   prdata;
		logic [15:0]   eos;
		logic          auto_end;
		logic          ist;
		logic          ppe_en;
		logic          ppe_sense;
		logic [2:0]    ppe_line;
		logic          cic;
		logic          standby;
		logic          shadow;
		logic          sh_end;
		logic          listen;
		logic          err_ncic;
		logic [31:0]   err_detail;
		logic [7:0]    tx_data;
		logic          tx_last;
		logic          tx_full;
		itsp_src_e     src;
		logic [7:0]    rx_data;
		logic          rx_full;
		logic          rx_end;
		itsp_acc_e     acc;
		itsp_bus_out_s bus;
	} itsp_state_s;

	itsp_state_s s_r;
	itsp_state_s s_nxt;

	// asserted views of the bus lines
	logic [7:0] dio_a;
	logic       dav_a;
	logic       nrfd_a;
	logic       ndac_a;
	logic       eoi_a;
	logic       atn_a;
	assign dio_a  = ~bus_i.dio;
	assign dav_a  = ~bus_i.dav;
	assign nrfd_a = ~bus_i.nrfd;
	assign ndac_a = ~bus_i.ndac;
	assign eoi_a  = ~bus_i.eoi;
	assign atn_a  = ~bus_i.atn;

	// string byte compare, seven or eight bits
	function automatic logic eos_match(input logic [7:0] b, input logic [15:0] cfg);
		if (cfg[ITSP_EOS_FC_BIT]) begin
			eos_match = (b == cfg[7:0]);
		end else begin
			eos_match = (b[6:0] == cfg[6:0]);
		end
	endfunction : eos_match

	// acceptor modes
	logic cmd_mode;
	logic shadow_mode;
	logic listen_mode;
	logic acc_on;
	logic acc_rdy;
	logic tx_end;
	logic identify;
	logic apb_setup;
	logic apb_done;
	logic mapped;
	logic [31:0] rd_val;
	assign cmd_mode    = atn_a && !s_r.cic;
	assign shadow_mode = s_r.cic && s_r.standby && s_r.shadow;
	assign listen_mode = s_r.listen && !atn_a && !s_r.cic;
	assign acc_on      = cmd_mode || shadow_mode || listen_mode;
	// a listener is ready only with an empty receive buffer
	assign acc_rdy     = cmd_mode || shadow_mode || !s_r.rx_full;
	// one string setup and one end setting serve every transfer
	assign tx_end      = (s_r.tx_last && s_r.auto_end)
	                   || (s_r.eos[ITSP_EOS_WE_BIT] && eos_match(s_r.tx_data, s_r.eos));
	assign identify    = eoi_a && atn_a && !s_r.cic;
	assign apb_setup   = psel && !penable && !s_r.pready;
	assign apb_done    = psel && penable && s_r.pready;

	// address decode and read mux
	always_comb begin
		mapped = 1'b1;
		rd_val = 32'h0000_0000;
		unique case (paddr)
			ITSP_ADDR_EOS:      rd_val = {16'h0000, s_r.eos};
			ITSP_ADDR_AUTO_END: rd_val = {31'h0000_0000, s_r.auto_end};
			ITSP_ADDR_IST:      rd_val = {31'h0000_0000, s_r.ist};
			ITSP_ADDR_PPE:      rd_val = {27'h000_0000, s_r.ppe_en, s_r.ppe_sense, s_r.ppe_line};
			ITSP_ADDR_CTRL:     rd_val = 32'h0000_0000;
			ITSP_ADDR_STATUS:   rd_val = {18'h0_0000, s_r.acc, s_r.src, s_r.tx_full, s_r.rx_end,
			                              s_r.rx_full, s_r.err_ncic, s_r.sh_end, s_r.shadow,
			                              s_r.standby, s_r.bus.atn_oe, s_r.cic, s_r.listen};
			ITSP_ADDR_ERR:      rd_val = s_r.err_detail;
			ITSP_ADDR_TXD:      rd_val = {23'h00_0000, s_r.tx_last, s_r.tx_data};
			ITSP_ADDR_RXD:      rd_val = {23'h00_0000, s_r.rx_end, s_r.rx_data};
			default:            mapped = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		s_nxt = s_r;

		// apb: answer one cycle after setup
		// read data latched at setup, before any read side effect
		s_nxt.pready  = apb_setup;
		s_nxt.pslverr = apb_setup && !mapped;
		if (apb_setup) begin
			s_nxt.prdata = rd_val;
		end

		// source handshake for written bytes, data sent exactly as given
		unique case (s_r.src)
			ITSP_SRC_IDLE: begin
				if (s_r.tx_full && !nrfd_a) begin
					s_nxt.bus.dio_oe = s_r.tx_data;
					s_nxt.bus.eoi_oe = tx_end;
					s_nxt.src        = ITSP_SRC_SETTLE;
				end
			end
			// data and end marker settle a cycle before DAV
			ITSP_SRC_SETTLE: begin
				s_nxt.bus.dav_oe = 1'b1;
				s_nxt.src        = ITSP_SRC_DAV;
			end
			ITSP_SRC_DAV: begin
				if (!ndac_a) begin
					s_nxt.bus.dav_oe = 1'b0;
					s_nxt.bus.dio_oe = 8'h00;
					s_nxt.bus.eoi_oe = 1'b0;
					s_nxt.tx_full    = 1'b0;
					s_nxt.src        = ITSP_SRC_IDLE;
				end
			end
			default: begin
				s_nxt.src = ITSP_SRC_IDLE;
			end
		endcase

		// acceptor handshake: listener, command taker or shadow
		unique case (s_r.acc)
			ITSP_ACC_OFF: begin
				s_nxt.bus.nrfd_oe = 1'b0;
				s_nxt.bus.ndac_oe = 1'b0;
				if (acc_on) begin
					s_nxt.bus.nrfd_oe = 1'b1;
					s_nxt.bus.ndac_oe = 1'b1;
					s_nxt.acc         = ITSP_ACC_READY;
				end
			end
			ITSP_ACC_READY: begin
				s_nxt.bus.nrfd_oe = !acc_rdy;
				s_nxt.bus.ndac_oe = 1'b1;
				if (!acc_on) begin
					s_nxt.bus.nrfd_oe = 1'b0;
					s_nxt.bus.ndac_oe = 1'b0;
					s_nxt.acc         = ITSP_ACC_OFF;
				end else if (dav_a && !s_r.bus.nrfd_oe) begin
					s_nxt.bus.nrfd_oe = 1'b1;
					s_nxt.bus.ndac_oe = 1'b0;
					s_nxt.acc         = ITSP_ACC_TAKEN;
					// poll commands: 0110 S PPP enables, 0111 xxxx disables
					if (cmd_mode) begin
						if (dio_a[6:4] == ITSP_CMD_PPC_GROUP) begin
							s_nxt.ppe_en    = 1'b1;
							s_nxt.ppe_sense = dio_a[ITSP_PPE_SENSE_BIT];
							s_nxt.ppe_line  = dio_a[2:0];
						end else if (dio_a[6:4] == (ITSP_CMD_PPC_GROUP + 3'h1)) begin
							s_nxt.ppe_en = 1'b0;
						end
					end else if (shadow_mode) begin
						s_nxt.sh_end = eoi_a;
					end else begin
						s_nxt.rx_data = dio_a;
						s_nxt.rx_full = 1'b1;
						if (eoi_a || (s_r.eos[ITSP_EOS_RT_BIT] && eos_match(dio_a, s_r.eos))) begin
							s_nxt.rx_end = 1'b1;
							s_nxt.listen = 1'b0;
						end
					end
				end
			end
			// NDAC pulled again only once the talker drops DAV
			ITSP_ACC_TAKEN: begin
				if (!dav_a) begin
					s_nxt.bus.ndac_oe = 1'b1;
					s_nxt.acc         = s_r.sh_end ? ITSP_ACC_HOLD : ITSP_ACC_READY;
				end
			end
			// kept until control is taken back or shadow cancelled
			ITSP_ACC_HOLD: begin
				s_nxt.bus.nrfd_oe = 1'b1;
				s_nxt.bus.ndac_oe = 1'b1;
			end
		endcase

		// parallel poll answer on the assigned line
		// released when identify ends, unless a byte is on the lines
		if (identify && s_r.ppe_en) begin
			s_nxt.bus.dio_oe = 8'h00;
			s_nxt.bus.dio_oe[s_r.ppe_line] = (s_r.ist == s_r.ppe_sense);
		end else if (s_r.src == ITSP_SRC_IDLE && !(s_r.tx_full && !nrfd_a)) begin
			s_nxt.bus.dio_oe = 8'h00;
		end

		// register writes and read side effects at the access edge
		if (apb_done && pwrite) begin
			unique case (paddr)
				ITSP_ADDR_EOS: begin
					s_nxt.err_detail = {16'h0000, s_r.eos};
					s_nxt.eos        = pwdata[15:0] & ITSP_EOS_MASK;
				end
				ITSP_ADDR_AUTO_END: begin
					s_nxt.err_detail = {31'h0000_0000, s_r.auto_end};
					s_nxt.auto_end   = |pwdata;
				end
				ITSP_ADDR_IST: begin
					s_nxt.err_detail = {31'h0000_0000, s_r.ist};
					s_nxt.ist        = |pwdata;
				end
				ITSP_ADDR_PPE: begin
					s_nxt.ppe_line  = pwdata[2:0];
					s_nxt.ppe_sense = pwdata[ITSP_PPE_SENSE_BIT];
					s_nxt.ppe_en    = pwdata[ITSP_PPE_EN_BIT];
				end
				ITSP_ADDR_CTRL: begin
					// controller and standby state survive a restore
					if (pwdata[ITSP_CTRL_DEFAULTS]) begin
						s_nxt.eos      = ITSP_EOS_RST;
						s_nxt.auto_end = ITSP_AUTO_END_RST;
						s_nxt.ist      = 1'b0;
						s_nxt.ppe_en   = 1'b0;
					end
					if (pwdata[ITSP_CTRL_CIC_SET]) begin
						s_nxt.cic     = 1'b1;
						s_nxt.standby = 1'b0;
					end
					if (pwdata[ITSP_CTRL_CIC_CLR]) begin
						s_nxt.cic     = 1'b0;
						s_nxt.standby = 1'b0;
						s_nxt.shadow  = 1'b0;
					end
					// a refused request leaves standby and shadow alone
					if (pwdata[ITSP_CTRL_STANDBY]) begin
						if (!s_r.cic) begin
							s_nxt.err_ncic = 1'b1;
						end else begin
							s_nxt.err_ncic = 1'b0;
							s_nxt.standby  = 1'b1;
							s_nxt.shadow   = pwdata[ITSP_CTRL_SHADOW];
							s_nxt.sh_end   = 1'b0;
						end
					end
					if ((pwdata[ITSP_CTRL_TAKE] && s_r.cic) || pwdata[ITSP_CTRL_SH_CANCEL]) begin
						s_nxt.shadow = 1'b0;
						s_nxt.sh_end = 1'b0;
						if (pwdata[ITSP_CTRL_TAKE] && s_r.cic) begin
							s_nxt.standby = 1'b0;
						end
						// a holdoff entered at this same edge is released too
						if (s_nxt.acc == ITSP_ACC_HOLD) begin
							s_nxt.bus.nrfd_oe = 1'b0;
							s_nxt.bus.ndac_oe = 1'b0;
							s_nxt.acc         = ITSP_ACC_OFF;
						end
					end
					if (pwdata[ITSP_CTRL_LISTEN]) begin
						s_nxt.listen = 1'b1;
					end
					if (pwdata[ITSP_CTRL_UNLISTEN]) begin
						s_nxt.listen = 1'b0;
					end
				end
				// a byte written while the last is still out is dropped
				ITSP_ADDR_TXD: begin
					if (!s_r.tx_full) begin
						s_nxt.tx_data = pwdata[7:0];
						s_nxt.tx_last = pwdata[ITSP_TXD_LAST_BIT];
						s_nxt.tx_full = 1'b1;
					end
				end
				default: begin
					s_nxt.err_detail = s_r.err_detail;
				end
			endcase
		end else if (apb_done && paddr == ITSP_ADDR_RXD) begin
			// a byte caught at this edge outlives a read of an empty buffer
			if (s_r.rx_full) begin
				s_nxt.rx_full = 1'b0;
				s_nxt.rx_end  = 1'b0;
			end
		end

		// attention follows control state, levels are always low when driven
		// standby drops ATN at the same access edge that takes the request
		s_nxt.bus.atn_oe = s_nxt.cic && !s_nxt.standby;
		s_nxt.bus.dio_o  = 8'h00;
		s_nxt.bus.dav_o  = 1'b0;
		s_nxt.bus.nrfd_o = 1'b0;
		s_nxt.bus.ndac_o = 1'b0;
		s_nxt.bus.eoi_o  = 1'b0;
		s_nxt.bus.atn_o  = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register
	// reset leaves every bus line released
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r          <= '0;
			s_r.eos      <= ITSP_EOS_RST;
			s_r.auto_end <= ITSP_AUTO_END_RST;
			s_r.src      <= ITSP_SRC_IDLE;
			s_r.acc      <= ITSP_ACC_OFF;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from the state register
	assign prdata  = s_r.prdata;
	assign pready  = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign bus_o   = s_r.bus;

endmodule : itsp_top
`default_nettype wire

// *** pkg/itsp_pkg.sv ***
// package: constants, register map and types of the termination, standby and poll block
package itsp_pkg;

	// register byte offsets
	localparam logic [7:0] ITSP_ADDR_EOS      = 8'h00;
	localparam logic [7:0] ITSP_ADDR_AUTO_END = 8'h04;
	localparam logic [7:0] ITSP_ADDR_IST      = 8'h08;
	localparam logic [7:0] ITSP_ADDR_PPE      = 8'h0C;
	localparam logic [7:0] ITSP_ADDR_CTRL     = 8'h10;
	localparam logic [7:0] ITSP_ADDR_STATUS   = 8'h14;
	localparam logic [7:0] ITSP_ADDR_ERR      = 8'h18;
	localparam logic [7:0] ITSP_ADDR_TXD      = 8'h1C;
	localparam logic [7:0] ITSP_ADDR_RXD      = 8'h20;

	// end-of-string word: match byte low, flags in the high byte
	localparam int          ITSP_EOS_RT_BIT = 10;
	localparam int          ITSP_EOS_WE_BIT = 11;
	localparam int          ITSP_EOS_FC_BIT = 12;
	localparam logic [15:0] ITSP_EOS_MASK   = 16'h1CFF;
	localparam logic [15:0] ITSP_EOS_RST    = 16'h0000;
	localparam logic        ITSP_AUTO_END_RST = 1'b1;

	// parallel poll configuration word
	localparam int ITSP_PPE_SENSE_BIT = 3;
	localparam int ITSP_PPE_EN_BIT    = 4;

	// control word bits, each acts when written as one
	localparam int ITSP_CTRL_STANDBY   = 0;
	localparam int ITSP_CTRL_SHADOW    = 1;
	localparam int ITSP_CTRL_TAKE      = 2;
	localparam int ITSP_CTRL_CIC_SET   = 3;
	localparam int ITSP_CTRL_LISTEN    = 4;
	localparam int ITSP_CTRL_DEFAULTS  = 5;
	localparam int ITSP_CTRL_SH_CANCEL = 6;
	localparam int ITSP_CTRL_CIC_CLR   = 7;
	localparam int ITSP_CTRL_UNLISTEN  = 8;

	// transmit word: byte low, last-byte marker above it
	localparam int ITSP_TXD_LAST_BIT = 8;
	localparam int ITSP_RXD_END_BIT  = 8;

	// remote poll commands: 0110 S PPP enables, 0111 xxxx disables
	localparam logic [2:0] ITSP_CMD_PPC_GROUP = 3'h6;

	typedef enum logic [1:0] {
		ITSP_ACC_OFF   = 2'b00,
		ITSP_ACC_READY = 2'b01,
		ITSP_ACC_TAKEN = 2'b10,
		ITSP_ACC_HOLD  = 2'b11
	} itsp_acc_e;

	typedef enum logic [1:0] {
		ITSP_SRC_IDLE   = 2'b00,
		ITSP_SRC_SETTLE = 2'b01,
		ITSP_SRC_DAV    = 2'b10
	} itsp_src_e;

	// bus lines as electrical levels, low is asserted
	typedef struct packed {
		logic [7:0] dio;
		logic       dav;
		logic       nrfd;
		logic       ndac;
		logic       eoi;
		logic       atn;
	} itsp_bus_in_s;

	// open-drain drive: _o is the level, _oe pulls the line while high
	typedef struct packed {
		logic [7:0] dio_o;
		logic [7:0] dio_oe;
		logic       dav_o;
		logic       dav_oe;
		logic       nrfd_o;
		logic       nrfd_oe;
		logic       ndac_o;
		logic       ndac_oe;
		logic       eoi_o;
		logic       eoi_oe;
		logic       atn_o;
		logic       atn_oe;
	} itsp_bus_out_s;

endpackage : itsp_pkg
